/* File: hdl/saf_pkg.sv */
// Shared constants and carrier types for the stereo audio FIFO port.
package saf_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_OCCUPANCY = 12'h004;
    localparam logic [11:0] ADDR_LEFT      = 12'h008;
    localparam logic [11:0] ADDR_RIGHT     = 12'h00c;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int CTL_IN_IRQ_EN  = 0;
    localparam int CTL_OUT_IRQ_EN = 1;
    localparam int CTL_IN_FLUSH   = 2;
    localparam int CTL_OUT_FLUSH  = 3;
    localparam int CTL_IN_PEND    = 8;
    localparam int CTL_OUT_PEND   = 9;

    // ------------------------------------------------------------------
    // Occupancy register field positions, each field 8 bits wide
    // ------------------------------------------------------------------
    localparam int OCC_LEFT_OUT_LSB  = 24;
    localparam int OCC_RIGHT_OUT_LSB = 16;
    localparam int OCC_LEFT_IN_LSB   = 8;
    localparam int OCC_RIGHT_IN_LSB  = 0;
    localparam int OCC_FIELD_W       = 8;

    // ------------------------------------------------------------------
    // Defaults, thresholds and reset values
    // ------------------------------------------------------------------
    localparam int DEF_SAMPLE_W = 24;
    localparam int DEF_DEPTH    = 128;
    localparam int LEVEL_NUM    = 3;
    localparam int LEVEL_DEN    = 4;

    typedef struct packed {
        logic out_flush;
        logic in_flush;
        logic out_irq_en;
        logic in_irq_en;
    } saf_ctrl_s;

    localparam saf_ctrl_s RST_CTRL = saf_ctrl_s'(4'h0);

    // One stereo sample frame; samples sit right-justified in each half.
    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } saf_pair_s;

    localparam saf_pair_s RST_PAIR = saf_pair_s'(64'h0);

endpackage

/* File: hdl/saf_fifo.sv */
// Single-clock sample FIFO with occupancy count and hold-clear input.
`timescale 1ns/1ps
module saf_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 128,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic          pclk,      // System clock.
    input  wire logic          presetn,   // Asynchronous reset, active low.
    input  wire logic          clear,     // Holds the FIFO empty while high.
    input  wire logic          push,      // Store push_data when not full.
    input  wire logic [W-1:0]  push_data, // Sample to store.
    input  wire logic          pop,       // Drop head sample when not empty.
    output logic      [W-1:0]  head,      // Oldest stored sample.
    output logic      [CW-1:0] count,     // Samples stored.
    output logic               full,      // No free entry.
    output logic               empty      // Nothing stored.
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } saf_fifo_s;

    saf_fifo_s st;
    saf_fifo_s next_st;

    assign head  = st.mem[st.rd];
    assign count = st.cnt;
    assign full  = (st.cnt == CW'(DEPTH));
    assign empty = (st.cnt == '0);

    always_comb begin
        logic do_push;
        logic do_pop;
        do_push = push & ~full;
        do_pop  = pop & ~empty;
        next_st = st;
        if (clear) begin
            next_st.wr  = '0;
            next_st.rd  = '0;
            next_st.cnt = '0;
        end else begin
            if (do_push) begin
                next_st.mem[st.wr] = push_data;
                next_st.wr         = st.wr + AW'(1);
            end
            if (do_pop) begin
                next_st.rd = st.rd + AW'(1);
            end
            next_st.cnt = st.cnt + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

/* File: hdl/saf_top.sv */
// Stereo audio FIFO port: APB register slave, four sample FIFOs, codec streams.
//
// Summary of operation
// - Input and output paths are separate build options.
// - Four FIFOs: input and output, left and right.
// - Sample width parameter: 16, 20, 24 or 32.
// - Output plays only when left and right present.
// - Four 32-bit registers at offsets 0, 4, 8, 12.
// - Control bit 0 enables input interrupt.
// - Control bit 1 enables output interrupt.
// - Control bit 2 holds input FIFOs cleared.
// - Control bit 3 holds output FIFOs cleared.
// - Control bits 8, 9 show pending conditions.
// - Occupancy high bytes: free output entries.
// - Occupancy low bytes: stored input samples.
// - Left port reads input, writes output sample.
// - Right port reads input, writes output sample.
// - Samples are right-justified from bit zero.
// - Input pending when either input FIFO 75% full.
// - Output pending when either output FIFO 75% free.
// - Interrupt when any pending condition is enabled.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module saf_top #(
    parameter int SAMPLE_W = saf_pkg::DEF_SAMPLE_W, // Bits per channel sample.
    parameter int DEPTH    = saf_pkg::DEF_DEPTH,    // Entries per FIFO.
    parameter bit IN_EN    = 1'b1,                  // Build the input path.
    parameter bit OUT_EN   = 1'b1                   // Build the output path.
) (
    input  wire logic              pclk,       // APB clock, 10 MHz.
    input  wire logic              presetn,    // Asynchronous reset, active low.
    input  wire logic              psel,       // APB select.
    input  wire logic              penable,    // APB access phase.
    input  wire logic              pwrite,     // APB write when high.
    input  wire logic [11:0]       paddr,      // APB byte address.
    input  wire logic [31:0]       pwdata,     // APB write data.
    output logic      [31:0]       prdata,     // APB read data.
    output logic                   pready,     // APB transfer done.
    output logic                   pslverr,    // APB error, unmapped address.
    output logic                   irq,        // Interrupt request, active high.
    input  wire logic              in_valid,   // Codec presents an input frame.
    input  wire saf_pkg::saf_pair_s in_sample, // Input frame, right-justified.
    output logic                   out_valid,  // Output frame is presented.
    output saf_pkg::saf_pair_s     out_sample, // Output frame, right-justified.
    input  wire logic              out_ready   // Codec takes the output frame.
);

    // ------------------------------------------------------------------
    // Derived sizes and elaboration checks
    // ------------------------------------------------------------------
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int HI_MARK =
        (saf_pkg::LEVEL_NUM * DEPTH + saf_pkg::LEVEL_DEN - 1) / saf_pkg::LEVEL_DEN;

    // The occupancy fields are eight bits, so a full count must fit in them.
    generate
        if (!(SAMPLE_W == 16 || SAMPLE_W == 20 ||
              SAMPLE_W == 24 || SAMPLE_W == 32)) begin : g_bad_width
            $error("saf_top: SAMPLE_W must be 16, 20, 24 or 32");
        end

        if (DEPTH < 4 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("saf_top: DEPTH must be a power of two from 4 to 128");
        end

        if (!IN_EN && !OUT_EN) begin : g_no_path
            $error("saf_top: at least one of IN_EN and OUT_EN must be set");
        end
    endgenerate

    // ------------------------------------------------------------------
    // FIFO index map
    // ------------------------------------------------------------------
    localparam int F_IN_L  = 0;
    localparam int F_IN_R  = 1;
    localparam int F_OUT_L = 2;
    localparam int F_OUT_R = 3;
    localparam int NF      = 4;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    // Everything but the FIFO storage, pointers and counts lives here.
    typedef struct packed {
        saf_pkg::saf_ctrl_s ctrl;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               irq;
        logic               out_valid;
        saf_pkg::saf_pair_s out_sample;
    } saf_state_s;

    localparam saf_state_s RST_STATE = '{
        ctrl:       saf_pkg::RST_CTRL,
        pready:     1'b0,
        pslverr:    1'b0,
        prdata:     32'h0,
        irq:        1'b0,
        out_valid:  1'b0,
        out_sample: saf_pkg::RST_PAIR
    };

    saf_state_s st;
    saf_state_s next_st;

    // ------------------------------------------------------------------
    // FIFO wiring
    // ------------------------------------------------------------------
    logic [NF-1:0]               f_push;
    logic [NF-1:0]               f_pop;
    logic [NF-1:0]               f_clear;
    logic [NF-1:0][SAMPLE_W-1:0] f_wdata;
    logic [NF-1:0][SAMPLE_W-1:0] f_head;
    logic [NF-1:0][CW-1:0]       f_count;
    logic [NF-1:0]               f_full;
    logic [NF-1:0]               f_empty;

    generate
        for (genvar i = 0; i < NF; i++) begin : g_fifo
            saf_fifo #(
                .W     (SAMPLE_W),
                .DEPTH (DEPTH),
                .CW    (CW)
            ) u_fifo (
                .pclk      (pclk),
                .presetn   (presetn),
                .clear     (f_clear[i]),
                .push      (f_push[i]),
                .push_data (f_wdata[i]),
                .pop       (f_pop[i]),
                .head      (f_head[i]),
                .count     (f_count[i]),
                .full      (f_full[i]),
                .empty     (f_empty[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Word index of a mapped register, taken from address bits 3:2.
    function automatic logic [1:0] reg_index(input logic [11:0] addr);
        return addr[3:2];
    endfunction

    // Only aligned words at the four documented offsets are mapped.
    function automatic logic reg_hit(input logic [11:0] addr);
        return (addr == saf_pkg::ADDR_CONTROL)   ||
               (addr == saf_pkg::ADDR_OCCUPANCY) ||
               (addr == saf_pkg::ADDR_LEFT)      ||
               (addr == saf_pkg::ADDR_RIGHT);
    endfunction

    // A count squeezed into an eight-bit occupancy field.
    function automatic logic [7:0] to_field(input logic [CW-1:0] n);
        return 8'(n);
    endfunction

    // Right-justified sample widened to a bus word with zero fill.
    function automatic logic [31:0] to_word(input logic [SAMPLE_W-1:0] s);
        return 32'(s);
    endfunction

    // ------------------------------------------------------------------
    // Level conditions
    // ------------------------------------------------------------------
    logic          in_pend;
    logic          out_pend;
    logic [CW-1:0] free_l;
    logic [CW-1:0] free_r;
    logic [31:0]   occ_word;
    logic [31:0]   ctrl_word;

    assign free_l = CW'(DEPTH) - f_count[F_OUT_L];
    assign free_r = CW'(DEPTH) - f_count[F_OUT_R];

    // Pending is a pure level, so it drops on its own once the host
    // drains or fills the FIFOs back past the mark.
    assign in_pend  = (f_count[F_IN_L] >= CW'(HI_MARK)) |
                      (f_count[F_IN_R] >= CW'(HI_MARK));

    assign out_pend = (free_l >= CW'(HI_MARK)) |
                      (free_r >= CW'(HI_MARK));

    always_comb begin
        occ_word = 32'h0;
        occ_word[saf_pkg::OCC_LEFT_OUT_LSB +: saf_pkg::OCC_FIELD_W]  =
            to_field(free_l);
        occ_word[saf_pkg::OCC_RIGHT_OUT_LSB +: saf_pkg::OCC_FIELD_W] =
            to_field(free_r);
        occ_word[saf_pkg::OCC_LEFT_IN_LSB +: saf_pkg::OCC_FIELD_W]   =
            to_field(f_count[F_IN_L]);
        occ_word[saf_pkg::OCC_RIGHT_IN_LSB +: saf_pkg::OCC_FIELD_W]  =
            to_field(f_count[F_IN_R]);
    end

    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[saf_pkg::CTL_IN_IRQ_EN]  = st.ctrl.in_irq_en;
        ctrl_word[saf_pkg::CTL_OUT_IRQ_EN] = st.ctrl.out_irq_en;
        ctrl_word[saf_pkg::CTL_IN_FLUSH]   = st.ctrl.in_flush;
        ctrl_word[saf_pkg::CTL_OUT_FLUSH]  = st.ctrl.out_flush;
        ctrl_word[saf_pkg::CTL_IN_PEND]    = in_pend;
        ctrl_word[saf_pkg::CTL_OUT_PEND]   = out_pend;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic       access;
        logic       mapped;
        logic [1:0] idx;
        logic       frame_ok;

        access   = psel & penable & ~st.pready;
        mapped   = reg_hit(paddr);
        idx      = reg_index(paddr);
        frame_ok = 1'b0;
        next_st  = st;
        f_push   = '0;
        f_pop    = '0;

        // Flushes hold the FIFO pointers at zero for as long as the bit
        // stays set; a disabled path keeps its FIFOs empty for good.
        f_clear[F_IN_L]  = st.ctrl.in_flush | ~IN_EN;
        f_clear[F_IN_R]  = st.ctrl.in_flush | ~IN_EN;
        f_clear[F_OUT_L] = st.ctrl.out_flush | ~OUT_EN;
        f_clear[F_OUT_R] = st.ctrl.out_flush | ~OUT_EN;

        // Codec side: an input frame is pushed to both input FIFOs together; a full one drops its half.
        f_wdata[F_IN_L] = in_sample.left[SAMPLE_W-1:0];
        f_wdata[F_IN_R] = in_sample.right[SAMPLE_W-1:0];
        if (IN_EN && in_valid) begin
            f_push[F_IN_L] = 1'b1;
            f_push[F_IN_R] = 1'b1;
        end

        // Host side writes to the output FIFOs.
        f_wdata[F_OUT_L] = pwdata[SAMPLE_W-1:0];
        f_wdata[F_OUT_R] = pwdata[SAMPLE_W-1:0];

        // APB: every access phase completes one cycle after it opens.
        next_st.pready  = access;
        next_st.pslverr = access & ~mapped;

        if (access) begin
            next_st.prdata = 32'h0;
            if (mapped) begin
                case (idx)
                    2'd0: begin
                        if (pwrite) begin
                            next_st.ctrl.in_irq_en  =
                                pwdata[saf_pkg::CTL_IN_IRQ_EN];
                            next_st.ctrl.out_irq_en =
                                pwdata[saf_pkg::CTL_OUT_IRQ_EN];
                            next_st.ctrl.in_flush   =
                                pwdata[saf_pkg::CTL_IN_FLUSH];
                            next_st.ctrl.out_flush  =
                                pwdata[saf_pkg::CTL_OUT_FLUSH];
                        end else begin
                            next_st.prdata = ctrl_word;
                        end
                    end

                    2'd1: begin
                        if (!pwrite) begin
                            next_st.prdata = occ_word;
                        end
                    end

                    2'd2: begin
                        if (pwrite) begin
                            // Full FIFO drops the word inside saf_fifo.
                            f_push[F_OUT_L] = OUT_EN;
                        end else if (IN_EN && !f_empty[F_IN_L]) begin
                            next_st.prdata = to_word(f_head[F_IN_L]);
                            f_pop[F_IN_L]  = 1'b1;
                        end
                    end

                    2'd3: begin
                        if (pwrite) begin
                            f_push[F_OUT_R] = OUT_EN;
                        end else if (IN_EN && !f_empty[F_IN_R]) begin
                            next_st.prdata = to_word(f_head[F_IN_R]);
                            f_pop[F_IN_R]  = 1'b1;
                        end
                    end

                    default: begin
                        next_st.prdata = 32'h0;
                    end
                endcase
            end
        end

        // Output stage: a frame leaves only with both halves in hand, so a
        // one-sided host stalls playback rather than skewing the channels.
        if (st.ctrl.out_flush) begin
            next_st.out_valid = 1'b0;
        end else if (!st.out_valid || out_ready) begin
            frame_ok = ~f_empty[F_OUT_L] & ~f_empty[F_OUT_R];
            next_st.out_valid = frame_ok;
            if (frame_ok) begin
                f_pop[F_OUT_L] = 1'b1;
                f_pop[F_OUT_R] = 1'b1;
                next_st.out_sample.left  = to_word(f_head[F_OUT_L]);
                next_st.out_sample.right = to_word(f_head[F_OUT_R]);
            end
        end

        next_st.irq = (in_pend & st.ctrl.in_irq_en) |
                      (out_pend & st.ctrl.out_irq_en);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from the state register
    // ------------------------------------------------------------------
    assign prdata     = st.prdata;
    assign pready     = st.pready;
    assign pslverr    = st.pslverr;
    assign irq        = st.irq;
    assign out_valid  = st.out_valid;
    assign out_sample = st.out_sample;

endmodule

/* File: tb/saf_top_asserts.sv */
// Port-level assertions for the stereo audio FIFO port.
`timescale 1ns/1ps
module saf_top_asserts #(
    parameter int SAMPLE_W = 24,
    parameter int DEPTH    = 128
) (
    input wire logic               pclk,       // Clock.
    input wire logic               presetn,    // Reset, active low.
    input wire logic               psel,       // Select.
    input wire logic               penable,    // Access.
    input wire logic               pwrite,     // Write.
    input wire logic [11:0]        paddr,      // Address.
    input wire logic [31:0]        pwdata,     // Write data.
    input wire logic [31:0]        prdata,     // Read data.
    input wire logic               pready,     // Done.
    input wire logic               pslverr,    // Error.
    input wire logic               irq,        // Interrupt.
    input wire logic               in_valid,   // Input frame.
    input wire saf_pkg::saf_pair_s in_sample,  // Input data.
    input wire logic               out_valid,  // Output frame.
    input wire saf_pkg::saf_pair_s out_sample, // Output data.
    input wire logic               out_ready   // Codec takes.
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && penable && !pready |=> pready)
        else $error("late pready");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel))
        else $error("stray pready");
    a_err_map: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
        12'h008, 12'h00c}))
        else $error("bad pslverr");
    a_ctl_resv: assert property (pready && !pwrite && paddr == saf_pkg::ADDR_CONTROL
        |-> prdata[31:10] == 22'h0 && prdata[7:4] == 4'h0)
        else $error("reserved bits set");
    a_irq_match: assert property (pready && !pwrite && paddr == saf_pkg::ADDR_CONTROL
        |-> irq == ((prdata[8] && prdata[0]) || (prdata[9] && prdata[1])))
        else $error("irq mismatch");
    a_rd_just: assert property (pready && !pwrite && (paddr == saf_pkg::ADDR_LEFT
        || paddr == saf_pkg::ADDR_RIGHT) |-> (prdata >> SAMPLE_W) == 32'h0)
        else $error("read not justified");
    a_occ_range: assert property (pready && !pwrite && paddr == saf_pkg::ADDR_OCCUPANCY
        |-> prdata[31:24] <= DEPTH && prdata[23:16] <= DEPTH && prdata[15:8] <= DEPTH
        && prdata[7:0] <= DEPTH)
        else $error("occupancy too big");
    // A flush during a stall drops the frame; the bench never does that.
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_sample))
        else $error("frame not held");
    a_flush_out: assert property (pready && pwrite && paddr == saf_pkg::ADDR_CONTROL
        && pwdata[3] |-> ##2 !out_valid)
        else $error("flush left frame");
    a_out_just: assert property (out_valid |-> (out_sample.left >> SAMPLE_W) == 32'h0
        && (out_sample.right >> SAMPLE_W) == 32'h0)
        else $error("output not justified");
endmodule

bind saf_top saf_top_asserts #(.SAMPLE_W(SAMPLE_W), .DEPTH(DEPTH)) saf_top_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid),
    .out_sample(out_sample), .out_ready(out_ready));

/* File: tb/saf_codec_model.sv */
// Behavioural codec at the far side of the sample streams.
`timescale 1ns/1ps
module saf_codec_model (
    input  wire logic               pclk,       // Clock.
    input  wire logic               presetn,    // Reset, active low.
    input  wire logic               stall,      // Refuse output frames.
    input  wire logic               send,       // Present send_frame next cycle.
    input  wire saf_pkg::saf_pair_s send_frame, // Frame to present.
    input  wire logic               out_valid,  // Frame offered.
    output logic                    in_valid,   // Frame presented.
    output saf_pkg::saf_pair_s      in_sample,  // Presented frame.
    output logic                    out_ready,  // Frame accepted.
    output logic [7:0]              taken_cnt   // Frames taken.
);
    assign out_ready = !stall;
    // Idle data lines toggle, so a stale frame cannot pass for a fresh one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            in_sample <= '0;
            taken_cnt <= 8'h00;
        end else begin
            in_valid <= send;
            in_sample <= send ? send_frame : ~in_sample;
            if (out_valid && out_ready) begin
                taken_cnt <= taken_cnt + 8'h01;
            end
        end
    end
endmodule

/* File: tb/test_stereo_audio_fifo_port.sv */
// Self-checking bench for the stereo audio FIFO port.
`timescale 1ns/1ps
module test_stereo_audio_fifo_port;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic        eexp;
    } saf_row_s;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic               stall = 1'b1;
    logic               send = 1'b0;
    saf_pkg::saf_pair_s send_frame = '0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq;
    logic               in_valid;
    logic               out_valid;
    logic               out_ready;
    saf_pkg::saf_pair_s in_sample;
    saf_pkg::saf_pair_s out_sample;
    logic [7:0]         taken_cnt;
    logic [31:0]        rd;
    logic               er;
    int                 errors = 0;
    int                 num_checks = 0;
    int                 cycles = 0;
    saf_row_s           rows [11];

    // Small depth keeps fill tests short: the pending mark is 6 of 8.
    saf_top #(.SAMPLE_W(16), .DEPTH(8)) saf_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .in_valid(in_valid),
        .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample),
        .out_ready(out_ready));
    saf_codec_model saf_codec_model_i (.pclk(pclk), .presetn(presetn), .stall(stall),
        .send(send), .send_frame(send_frame), .out_valid(out_valid), .in_valid(in_valid),
        .in_sample(in_sample), .out_ready(out_ready), .taken_cnt(taken_cnt));

    initial begin
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic send_in(input logic [31:0] l, input logic [31:0] r);
        @(posedge pclk);
        send <= 1'b1;
        send_frame <= {l, r};
        @(posedge pclk);
        send <= 1'b0;
    endtask

    initial begin
        rows = '{
            '{0, 12'h000, 32'h0, 32'h200, 0},
            '{0, 12'h004, 32'h0, 32'h08080000, 0},
            '{0, 12'h010, 32'h0, 32'h0, 1},
            '{1, 12'h004, 32'hffffffff, 32'h0, 0},
            '{0, 12'h004, 32'h0, 32'h08080000, 0},
            '{1, 12'h000, 32'h3, 32'h0, 0},
            '{0, 12'h000, 32'h0, 32'h203, 0},
            '{1, 12'h008, 32'habcd5a5a, 32'h0, 0},
            '{0, 12'h004, 32'h0, 32'h07080000, 0},
            '{1, 12'h00c, 32'hffff1234, 32'h0, 0},
            '{0, 12'h004, 32'h0, 32'h08080000, 0}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            chk("row data", rd, rows[i].rexp);
            chk("row err", 32'(er), 32'(rows[i].eexp));
        end
        chk("out valid", 32'(out_valid), 32'h1);
        chk("out left", out_sample.left, 32'h5a5a);
        chk("out right", out_sample.right, 32'h1234);
        chk("irq out", 32'(irq), 32'h1);
        stall <= 1'b0;
        for (int k = 0; k < 10 && taken_cnt !== 8'h01; k++) @(posedge pclk);
        chk("taken", 32'(taken_cnt), 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'(irq), 32'h0);
        for (int i = 0; i < 5; i++) send_in({16'hdead, 16'(16'h0100 + i)}, 32'hbeef0200);
        rdx(12'h000, 32'h201, "ctl below mark");
        send_in(32'hdead0105, 32'hbeef0200);
        rdx(12'h000, 32'h301, "ctl at mark");
        chk("irq in", 32'(irq), 32'h1);
        rdx(12'h004, 32'h08080606, "occ in");
        rdx(12'h008, 32'h100, "left pop");
        rdx(12'h00c, 32'h200, "right pop");
        rdx(12'h000, 32'h201, "ctl cleared");
        apb(1'b1, 12'h000, 32'h5);
        rdx(12'h004, 32'h08080000, "in flushed");
        rdx(12'h008, 32'h0, "empty read");
        apb(1'b1, 12'h000, 32'h1);
        for (int i = 0; i < 10; i++) apb(1'b1, 12'h008, 32'h77);
        rdx(12'h004, 32'h80000, "left full");
        chk("no half frame", 32'(out_valid), 32'h0);
        apb(1'b1, 12'h000, 32'h9);
        rdx(12'h004, 32'h08080000, "out flushed");
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdx(12'h000, 32'h200, "ctl after reset");
        chk("irq reset", 32'(irq), 32'h0);
        rdx(12'h004, 32'h08080000, "occ reset");
        end_sim();
    end
endmodule
